// >>> pkg/gpa_pkg.sv
// Constants, register map and types for the port A pin block
package gpa_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 32;
   localparam int          NPINS  = 8;
   localparam int          NANA   = 4;

   typedef logic [NPINS-1:0] gpa_pins_t;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_LEVEL  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DIR    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PULLUP = 8'h08;

   // ************************************************************
   // Implemented bits, read-only bits and reset values
   // ************************************************************
   localparam gpa_pins_t LEVEL_RD_MASK = 8'hef;   // Bit 4 absent
   localparam gpa_pins_t LEVEL_WR_MASK = 8'hcf;   // Bit 5 input only
   localparam gpa_pins_t LATCH_RST     = 8'h00;
   localparam gpa_pins_t DIR_WR_MASK   = 8'hcf;
   localparam gpa_pins_t DIR_FORCE_ONE = 8'h20;   // Pin 5 always input
   localparam gpa_pins_t DIR_RST       = 8'hef;
   localparam gpa_pins_t PULL_MASK     = 8'h2f;
   localparam gpa_pins_t PULL_RST      = 8'h2f;

   // ************************************************************
   // Pin capabilities
   // ************************************************************
   localparam gpa_pins_t ALT_LO_MASK = 8'hc7;     // Pins 0,1,2,6,7
   localparam gpa_pins_t ALT_HI_MASK = 8'h44;     // Pins 2,6
   localparam gpa_pins_t OUT_MASK    = 8'hcf;     // Pin 5 never drives
   localparam int        PIN_OD      = 7;
   localparam int        PIN_IN_ONLY = 5;

   // ************************************************************
   // Bus answers and states
   // ************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] PROT_W      = 2'h3;

   typedef enum logic [0:0] {WS_COLLECT = 1'b0, WS_RESP = 1'b1} gpa_wr_e;
   typedef enum logic [0:0] {RS_IDLE = 1'b0, RS_DATA = 1'b1} gpa_rd_e;

endpackage

// >>> pkg/gpa_in_if.sv
// Carrier for raw pin levels and their synchronised copies
`timescale 1ns/10ps
interface gpa_in_if;
   import gpa_pkg::*;
   gpa_pins_t raw;
   gpa_pins_t level;

   modport sync (input raw, output level);
   modport core (output raw, input level);
endinterface

// >>> rtl/gpa_pin_sync.sv
// Three-stage input synchroniser with agreement filter for the pins
`timescale 1ns/10ps
module gpa_pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Pin levels in and filtered levels out
   gpa_in_if.sync    pins
);
   import gpa_pkg::*;

   logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r;
   logic [WIDTH-1:0] lvl_nxt;

   // A level counts once the second and third stage agree
   always_comb begin
      lvl_nxt = lvl_r;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            lvl_nxt[i] = s3_r[i];
         end
      end
   end

   // Stage registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         lvl_r <= '0;
      end else begin
         s1_r  <= pins.raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   assign pins.level = lvl_r;

endmodule

// >>> rtl/gpa_port.sv
// Port A pin block: registers, output priority mux, pull-ups, AXI4-Lite slave
// Summary of operation
// - Pin 7 only pulls low or releases
// - Pin 7 has a filtered digital input
// - Highest priority enabled function owns pin
// - Fixed per-pin priority order, port lowest
// - Outputs still drive on analog pins
// - Analog functions connect only when analog selected
// - Level bits read pin state, writable
// - Level bit 5 is read-only pin 5
// - Bit 4, pull-up bits 7:6 read 0
// - Direction 1 is input, resets to 1
// - Direction bit 5 always reads 1
// - Pull-up bits 0-3,5 read/write, reset 1
// - Pull-up needs global, input, bit, digital, except pin 5 under master clear
// - Level write updates latch, read returns pins
// - Analog pin reads 0 in level register
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module gpa_port (
   // Clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // AXI4-Lite write address and data
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [gpa_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   input  wire logic [gpa_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [gpa_pkg::DATA_W/8-1:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   output logic [1:0]                         s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   input  wire logic [gpa_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [gpa_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   // Neighbouring control
   input  wire logic [gpa_pkg::NANA-1:0]      analog_select_reg_a,
   input  wire logic                          global_pullup_control,
   input  wire logic                          master_clear_input,
   // Alternate-function output requests
   input  wire gpa_pkg::gpa_pins_t            alt_lo_oe,
   input  wire gpa_pkg::gpa_pins_t            alt_lo_out,
   input  wire gpa_pkg::gpa_pins_t            alt_hi_oe,
   input  wire gpa_pkg::gpa_pins_t            alt_hi_out,
   // Pins
   input  wire gpa_pkg::gpa_pins_t            pin_in,
   output gpa_pkg::gpa_pins_t                 pin_out,
   output gpa_pkg::gpa_pins_t                 pin_oe,
   output gpa_pkg::gpa_pins_t                 pin_pullup,
   output logic [gpa_pkg::NANA-1:0]           analog_connect,
   output gpa_pkg::gpa_pins_t                 pin_digital_in
);
   import gpa_pkg::*;

   // ************************************************************
   // Input synchronisation
   // ************************************************************
   gpa_in_if in_bus ();
   assign in_bus.raw = pin_in;

   // Pin 7 input passes the same agreement filter as a Schmitt stage
   gpa_pin_sync #(.WIDTH(NPINS)) gpa_pin_sync_i (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pins    (in_bus.sync)
   );

   // ************************************************************
   // State
   // ************************************************************
   gpa_pins_t           latch_r, latch_nxt;
   gpa_pins_t           dir_r, dir_nxt;
   gpa_pins_t           pull_r, pull_nxt;
   gpa_pins_t           out_r, out_nxt, oe_r, oe_nxt, pu_r, pu_nxt, din_r;
   logic [NANA-1:0]     ana_r;
   gpa_pins_t           ana_pins, dig_level;
   gpa_wr_e             ws_r, ws_nxt;
   gpa_rd_e             rs_r, rs_nxt;
   logic                aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt, wr_addr;
   logic [DATA_W-1:0]   wdata_r, wdata_nxt, wr_data;
   logic                wstrb0_r, wstrb0_nxt, wr_strb0;
   logic                awready_r, awready_nxt, wready_r, wready_nxt;
   logic                arready_r, arready_nxt;
   logic [1:0]          bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [DATA_W-1:0]   rdata_r, rdata_nxt;
   logic                aw_take, w_take, ar_take;

   assign ana_pins  = {{(NPINS-NANA){1'b0}}, analog_select_reg_a};
   // Analog pins read 0, bit 4 reads 0, pin 5 reads its own level
   assign dig_level = in_bus.level & ~ana_pins & LEVEL_RD_MASK;

   // ************************************************************
   // AXI4-Lite write path
   // ************************************************************
   assign aw_take = s_axi_awvalid & awready_r;
   assign w_take  = s_axi_wvalid & wready_r;

   // Address and data are taken in either order, then applied together
   always_comb begin
      ws_nxt      = ws_r;
      aw_held_nxt = aw_held_r | aw_take;
      w_held_nxt  = w_held_r | w_take;
      awaddr_nxt  = aw_take ? s_axi_awaddr : awaddr_r;
      wdata_nxt   = w_take ? s_axi_wdata : wdata_r;
      wstrb0_nxt  = w_take ? s_axi_wstrb[0] : wstrb0_r;
      wr_addr     = awaddr_nxt;
      wr_data     = wdata_nxt;
      wr_strb0    = wstrb0_nxt;
      bresp_nxt   = bresp_r;
      latch_nxt   = latch_r;
      dir_nxt     = dir_r;
      pull_nxt    = pull_r;
      case (ws_r)
         WS_COLLECT: begin
            if (aw_held_nxt && w_held_nxt) begin
               ws_nxt      = WS_RESP;
               aw_held_nxt = 1'b0;
               w_held_nxt  = 1'b0;
               bresp_nxt   = RESP_OKAY;
               case (wr_addr)
                  OFS_LEVEL: begin
                     // Only the latch changes; reads still show the pins
                     if (wr_strb0) begin
                        latch_nxt = (latch_r & ~LEVEL_WR_MASK)
                                  | (wr_data[NPINS-1:0] & LEVEL_WR_MASK);
                     end
                  end
                  OFS_DIR: begin
                     if (wr_strb0) begin
                        dir_nxt = (wr_data[NPINS-1:0] & DIR_WR_MASK)
                                | DIR_FORCE_ONE;
                     end
                  end
                  OFS_PULLUP: begin
                     if (wr_strb0) begin
                        pull_nxt = wr_data[NPINS-1:0] & PULL_MASK;
                     end
                  end
                  default: begin
                     bresp_nxt = RESP_SLVERR;
                  end
               endcase
            end
         end
         WS_RESP: begin
            if (s_axi_bready) begin
               ws_nxt = WS_COLLECT;
            end
         end
         default: begin
            ws_nxt = WS_COLLECT;
         end
      endcase
      awready_nxt = (ws_nxt == WS_COLLECT) && !aw_held_nxt;
      wready_nxt  = (ws_nxt == WS_COLLECT) && !w_held_nxt;
   end

   // ************************************************************
   // AXI4-Lite read path
   // ************************************************************
   assign ar_take = s_axi_arvalid & arready_r;

   // Read data is captured at the address handshake
   always_comb begin
      rs_nxt    = rs_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      case (rs_r)
         RS_IDLE: begin
            if (ar_take) begin
               rs_nxt    = RS_DATA;
               rresp_nxt = RESP_OKAY;
               rdata_nxt = '0;
               case (s_axi_araddr)
                  OFS_LEVEL:  rdata_nxt[NPINS-1:0] = dig_level;
                  OFS_DIR:    rdata_nxt[NPINS-1:0] = dir_r;
                  OFS_PULLUP: rdata_nxt[NPINS-1:0] = pull_r;
                  default:    rresp_nxt = RESP_SLVERR;
               endcase
            end
         end
         RS_DATA: begin
            if (s_axi_rready) begin
               rs_nxt = RS_IDLE;
            end
         end
         default: begin
            rs_nxt = RS_IDLE;
         end
      endcase
      arready_nxt = (rs_nxt == RS_IDLE);
   end

   // ************************************************************
   // Output priority and pull-up logic
   // ************************************************************
   always_comb begin
      logic own_alt;
      own_alt = 1'b0;
      out_nxt = '0;
      oe_nxt  = '0;
      pu_nxt  = '0;
      for (int i = 0; i < NPINS; i++) begin
         // Port owns the pin by default, driver on when direction is 0
         out_nxt[i] = latch_r[i];
         oe_nxt[i]  = !dir_r[i];
         own_alt    = 1'b0;
         // Later assignment wins, so higher priority sits lower; analog ignored
         if (alt_lo_oe[i] && ALT_LO_MASK[i]) begin
            out_nxt[i] = alt_lo_out[i];
            oe_nxt[i]  = 1'b1;
            own_alt    = 1'b1;
         end
         if (alt_hi_oe[i] && ALT_HI_MASK[i]) begin
            out_nxt[i] = alt_hi_out[i];
            oe_nxt[i]  = 1'b1;
            own_alt    = 1'b1;
         end
         oe_nxt[i] = oe_nxt[i] & OUT_MASK[i];
         // Weak pull-up only on a digital input the port still owns
         pu_nxt[i] = global_pullup_control && dir_r[i] && pull_r[i]
                   && !ana_pins[i] && !own_alt && PULL_MASK[i];
      end
      // Open-drain pin: enable only while pulling low, never drive high
      oe_nxt[PIN_OD]  = oe_nxt[PIN_OD] & !out_nxt[PIN_OD];
      out_nxt[PIN_OD] = 1'b0;
      // Master clear use keeps its pull-up regardless of software
      pu_nxt[PIN_IN_ONLY] = pu_nxt[PIN_IN_ONLY] | master_clear_input;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_r   <= LATCH_RST;
         dir_r     <= DIR_RST;
         pull_r    <= PULL_RST;
         ws_r      <= WS_COLLECT;
         rs_r      <= RS_IDLE;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb0_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         arready_r <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
         out_r     <= '0;
         oe_r      <= '0;
         pu_r      <= '0;
         ana_r     <= '0;
         din_r     <= '0;
      end else begin
         latch_r   <= latch_nxt;
         dir_r     <= dir_nxt;
         pull_r    <= pull_nxt;
         ws_r      <= ws_nxt;
         rs_r      <= rs_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb0_r  <= wstrb0_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         arready_r <= arready_nxt;
         bresp_r   <= bresp_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         out_r     <= out_nxt;
         oe_r      <= oe_nxt;
         pu_r      <= pu_nxt;
         ana_r     <= analog_select_reg_a;
         din_r     <= dig_level;
      end
   end

   // Port outputs straight from flops
   assign s_axi_awready  = awready_r;
   assign s_axi_wready   = wready_r;
   assign s_axi_bvalid   = (ws_r == WS_RESP);
   assign s_axi_bresp    = bresp_r;
   assign s_axi_arready  = arready_r;
   assign s_axi_rvalid   = (rs_r == RS_DATA);
   assign s_axi_rdata    = rdata_r;
   assign s_axi_rresp    = rresp_r;
   assign pin_out        = out_r;
   assign pin_oe         = oe_r;
   assign pin_pullup     = pu_r;
   assign analog_connect = ana_r;
   assign pin_digital_in = din_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence lvl_write_s;
      aw_take && w_take && s_axi_awaddr == OFS_LEVEL && s_axi_wstrb[0]
         && !alt_lo_oe[0] && !alt_hi_oe[0] && ws_r == WS_COLLECT
         && !aw_held_r && !w_held_r;
   endsequence

   od_no_high_a: assert property (!pin_out[PIN_OD])
      else $error("open-drain pin drives high");
   od_low_a: assert property (pin_oe[PIN_OD] |-> $past(!alt_lo_oe[PIN_OD]
      ? (!latch_r[PIN_OD] && !dir_r[PIN_OD]) : !alt_lo_out[PIN_OD]))
      else $error("open-drain enable without low request");
   hi_prio_a: assert property (alt_hi_oe[6] |=> pin_oe[6]
      && pin_out[6] == $past(alt_hi_out[6]))
      else $error("highest function lost pin 6");
   analog_drive_a: assert property (analog_select_reg_a[2] && alt_lo_oe[2]
      && !alt_hi_oe[2] |=> pin_oe[2] && pin_out[2] == $past(alt_lo_out[2]))
      else $error("analog pin output blocked");
   port_oe_a: assert property (!alt_lo_oe[0] && !alt_hi_oe[0]
      |=> pin_oe[0] == !$past(dir_r[0]))
      else $error("port enable not inverse direction");
   in_only_a: assert property (!pin_oe[PIN_IN_ONLY] && dir_r[PIN_IN_ONLY])
      else $error("pin 5 drives or reads as output");
   pull_cond_a: assert property (pin_pullup[0] |-> $past(global_pullup_control
      && dir_r[0] && pull_r[0] && !analog_select_reg_a[0]))
      else $error("pull-up on without all conditions");
   rd_zero_a: assert property (s_axi_rvalid |-> !s_axi_rdata[4]
      && s_axi_rdata[DATA_W-1:NPINS] == '0)
      else $error("unimplemented bits read nonzero");
   ana_read_a: assert property (ar_take && s_axi_araddr == OFS_LEVEL
      && analog_select_reg_a[1] |=> !s_axi_rdata[1])
      else $error("analog pin read as one");
   latch_wr_a: assert property (lvl_write_s ##1 (!alt_lo_oe[0] && !alt_hi_oe[0])
      |=> pin_out[0] == $past(s_axi_wdata[0], 2))
      else $error("level write missed latch");
   ana_conn_a: assert property (##1 analog_connect == $past(analog_select_reg_a))
      else $error("analog connect not following select");

endmodule

// >>> testbench/gpa_board.sv
// Board model that resolves each port A pin from all parties
`timescale 1ns/10ps
module gpa_board
   import gpa_pkg::*;
(
   // Clock
   input  wire logic               aclk,
   // Device side of the pins
   input  wire gpa_pkg::gpa_pins_t pin_out,
   input  wire gpa_pkg::gpa_pins_t pin_oe,
   input  wire gpa_pkg::gpa_pins_t pin_pullup,
   // External drive commanded by the bench
   input  wire gpa_pkg::gpa_pins_t ext_en,
   input  wire gpa_pkg::gpa_pins_t ext_val,
   // Resolved pin levels
   output gpa_pkg::gpa_pins_t      pin_in
);
   gpa_pins_t float_r = 8'h55;

   // A pin nobody holds flips every cycle, so the agreement filter keeps its last settled level
   always @(posedge aclk) begin
      float_r <= ~float_r;
   end

   // Device driver wins over board drive, board drive over weak pull-up
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pin_pullup[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = float_r[i];
         end
      end
   end
endmodule

// >>> testbench/gpa_port_test.sv
// Self-checking bench for the port A pin block
`timescale 1ns/10ps
module gpa_port_test;
   import gpa_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] analog_select_reg_a = 0, analog_connect;
   logic global_pullup_control = 0, master_clear_input = 0;
   gpa_pins_t alt_lo_oe = 0, alt_lo_out = 0, alt_hi_oe = 0, alt_hi_out = 0;
   gpa_pins_t ext_en = 8'hff, ext_val = 8'h00;
   gpa_pins_t pin_in, pin_out, pin_oe, pin_pullup, pin_digital_in;
   int mismatches = 0, cmp_count = 0, cyc = 0;

   // ************************************************************
   // Design, board and clock
   // ************************************************************
   gpa_port gpa_port_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .analog_select_reg_a, .global_pullup_control, .master_clear_input,
      .alt_lo_oe, .alt_lo_out, .alt_hi_oe, .alt_hi_out, .pin_in, .pin_out, .pin_oe,
      .pin_pullup, .analog_connect, .pin_digital_in);
   gpa_board gpa_board_i (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);

   // Clock and hang guard
   always #10 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         close_out();
      end
   end

   // ************************************************************
   // Compare, bus and timing helpers
   // ************************************************************
   task automatic miss(input string what);
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
   endtask
   task automatic chk_pins(input gpa_pins_t got, input gpa_pins_t exp);
      cmp_count++;
      if (got !== exp) miss($sformatf("pins %h expected %h", got, exp));
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) miss($sformatf("word %h expected %h", got, exp));
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) miss($sformatf("resp %h expected %h", got, exp));
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask
   // Write one word, then judge the response code
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_d, w_d, aw_t, w_t;
      aw_d = 0;
      w_d = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (aw_t) begin
            s_axi_awvalid <= 1'b0;
            aw_d = 1;
         end
         if (w_t) begin
            s_axi_wvalid <= 1'b0;
            w_d = 1;
         end
      end
      s_axi_bready <= 1'b1;
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      chk_resp(s_axi_bresp, er);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   // Read one word, then judge data and response code
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      chk_word(s_axi_rdata, ed);
      chk_resp(s_axi_rresp, er);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rd_chk(OFS_DIR, 32'h0000_00ef, RESP_OKAY);
      rd_chk(OFS_PULLUP, 32'h0000_002f, RESP_OKAY);
      rd_chk(OFS_LEVEL, 32'h0000_0000, RESP_OKAY);
      chk_pins(pin_oe, 8'h00);
   endtask
   task automatic t_level();
      ext_val <= 8'hff;
      settle(6);
      rd_chk(OFS_LEVEL, 32'h0000_00ef, RESP_OKAY);
      @(posedge aclk);
      analog_select_reg_a <= 4'h6;
      settle(4);
      rd_chk(OFS_LEVEL, 32'h0000_00e9, RESP_OKAY);
      chk_pins({4'h0, analog_connect}, 8'h06);
      chk_pins(pin_digital_in, 8'he9);
   endtask
   task automatic t_drive();
      ext_en <= 8'hb0;
      ext_val <= 8'h80;
      analog_select_reg_a <= 4'h0;
      reg_wr(OFS_DIR, 32'h0, RESP_OKAY);
      rd_chk(OFS_DIR, 32'h0000_0020, RESP_OKAY);
      settle(3);
      chk_pins(pin_oe, 8'hcf);
      chk_pins(pin_out, 8'h00);
      reg_wr(OFS_LEVEL, 32'hff, RESP_OKAY);
      settle(3);
      chk_pins(pin_out, 8'h4f);
      chk_pins(pin_oe, 8'h4f);
      settle(4);
      rd_chk(OFS_LEVEL, 32'h0000_00cf, RESP_OKAY);
      ext_val <= 8'ha0;
      reg_wr(OFS_LEVEL, 32'h00, RESP_OKAY);
      settle(6);
      rd_chk(OFS_LEVEL, 32'h0000_0020, RESP_OKAY);
   endtask
   task automatic t_prio();
      @(posedge aclk);
      alt_lo_oe <= 8'hff;
      alt_lo_out <= 8'hff;
      analog_select_reg_a <= 4'hf;
      settle(3);
      chk_pins(pin_out, 8'h47);
      chk_pins(pin_oe, 8'h4f);
      @(posedge aclk);
      alt_hi_oe <= 8'hff;
      settle(3);
      chk_pins(pin_out, 8'h03);
      chk_pins(pin_oe, 8'h4f);
      @(posedge aclk);
      alt_lo_out <= 8'h7f;
      settle(3);
      chk_pins(pin_oe, 8'hcf);
      chk_pins(pin_out, 8'h03);
      @(posedge aclk);
      alt_lo_oe <= 8'h00;
      alt_hi_oe <= 8'h00;
      analog_select_reg_a <= 4'h0;
   endtask
   task automatic t_pullup();
      reg_wr(OFS_DIR, 32'hff, RESP_OKAY);
      reg_wr(OFS_PULLUP, 32'hff, RESP_OKAY);
      rd_chk(OFS_PULLUP, 32'h0000_002f, RESP_OKAY);
      global_pullup_control <= 1'b1;
      settle(3);
      chk_pins(pin_pullup, 8'h2f);
      @(posedge aclk);
      analog_select_reg_a <= 4'h3;
      settle(3);
      chk_pins(pin_pullup, 8'h2c);
      @(posedge aclk);
      global_pullup_control <= 1'b0;
      settle(3);
      chk_pins(pin_pullup, 8'h00);
      @(posedge aclk);
      master_clear_input <= 1'b1;
      settle(3);
      chk_pins(pin_pullup, 8'h20);
      @(posedge aclk);
      master_clear_input <= 1'b0;
      global_pullup_control <= 1'b1;
      analog_select_reg_a <= 4'h0;
      reg_wr(OFS_DIR, 32'hee, RESP_OKAY);
      settle(3);
      chk_pins(pin_pullup, 8'h2e);
      reg_wr(OFS_PULLUP, 32'h00, RESP_OKAY);
      settle(3);
      chk_pins(pin_pullup, 8'h00);
   endtask
   task automatic t_unmapped();
      reg_wr(8'h0c, 32'hff, RESP_SLVERR);
      rd_chk(8'h0c, 32'h0, RESP_SLVERR);
      rd_chk(OFS_DIR, 32'h0000_00ee, RESP_OKAY);
   endtask

   // Verdict and end of run
   task automatic close_out();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_reset();
      t_level();
      t_drive();
      t_prio();
      t_pullup();
      t_unmapped();
      close_out();
   end
endmodule
